//--- dv/eis_pin_model.sv
// Board model: drives the port pins at the levels the bench asks for.
// Assumes the bench changes its request only just after a clk edge.
`timescale 1ns/1ps

module eis_pin_model (
	input  wire        clk,
	input  wire [14:0] drive,
	output reg  [3:0]  porta,
	output reg  [2:0]  portf,
	output reg  [7:0]  portb
);
	// Pins idle high so reset sees no event
	initial {portb, portf, porta} = 15'h7fff;

	// Board lags the request by one edge, like a real driver
	always @(posedge clk) begin
		{portb, portf, porta} <= drive;
	end
endmodule

//--- dv/eis_top_chk.sv
// Port checks for the external sense and vector block.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps

module eis_chk (
	input wire       clk,
	input wire       rst,
	input wire       avs_read,
	input wire       avs_write,
	input wire       avs_waitrequest,
	input wire       clock_controller_timebase,
	input wire       safe_oscillator_monitor,
	input wire       halt_mode,
	input wire       active_halt_mode,
	input wire       irq_req,
	input wire [3:0] irq_slot,
	input wire       halt_wake,
	input wire [3:0] ext_pending
);
	// ----------------------------------------
	// Clocking
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Exactly one wait cycle, low for one cycle only
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest not low one cycle after request");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	reset_idle_a: assert property ($fell(rst) |-> avs_waitrequest && !irq_req && irq_slot == 4'hf && ext_pending == 4'h0 && !halt_wake)
		else $error("outputs not idle after reset");
	slot_none_a: assert property (!irq_req |-> irq_slot == 4'hf)
		else $error("slot shown with no request");
	ext_a_src_a: assert property (irq_req && irq_slot == 4'h2 |-> ext_pending[0])
		else $error("slot two without port A request");
	ext_prio_a: assert property (ext_pending[0] |-> irq_req && irq_slot <= 4'h2 && irq_slot != 4'h0)
		else $error("port A request lost priority");
	b_high_slot_a: assert property (irq_slot == 4'h5 |-> ext_pending == 4'h8)
		else $error("slot five with wrong group state");
	clk_share_a: assert property (clock_controller_timebase || safe_oscillator_monitor |-> ##[1:3] irq_slot == 4'h1)
		else $error("clock sources not on slot one");
	ahalt_wake_a: assert property (active_halt_mode
		&& (clock_controller_timebase || safe_oscillator_monitor) |-> ##[1:3] halt_wake)
		else $error("no wake from active halt");
	halt_ext_a: assert property (halt_mode && !active_halt_mode && ext_pending != 4'h0 |-> ##[0:2] halt_wake)
		else $error("external request did not wake halt");
endmodule

bind eis_top eis_chk u_chk (.clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .clock_controller_timebase(clock_controller_timebase),
	.safe_oscillator_monitor(safe_oscillator_monitor), .halt_mode(halt_mode),
	.active_halt_mode(active_halt_mode), .irq_req(irq_req), .irq_slot(irq_slot),
	.halt_wake(halt_wake), .ext_pending(ext_pending));

//--- dv/tb_eis_top.sv
// Self-checking bench for the external sense and vector block.
// Assumes eis_top, the pin model and the checker are compiled first.
`timescale 1ns/1ps
`include "eis_defs.vh"

module tb_eis_top;
	reg         clk;
	reg         rst;
	reg  [3:0]  avs_address;
	reg         avs_read;
	reg         avs_write;
	reg  [31:0] avs_writedata;
	wire [31:0] avs_readdata;
	wire        avs_waitrequest;
	wire [3:0]  porta_pins;
	wire [2:0]  portf_pins;
	wire [7:0]  portb_pins;
	reg  [14:0] pin_drv;   // Levels asked of the board
	reg  [8:0]  per;       // Peripheral request lines
	reg         halt_mode;
	reg         active_halt_mode;
	reg         cpu_ack;
	reg  [3:0]  cpu_ack_slot;
	wire        irq_req;
	wire [3:0]  irq_slot;
	wire        halt_wake;
	wire [3:0]  ext_pending;
	reg  [31:0] rd;        // Last read data
	integer     failures;
	integer     n_checks;
	integer     g;
	integer     c;
	integer     n;

	eis_pin_model u_pins (.clk(clk), .drive(pin_drv), .porta(porta_pins),
		.portf(portf_pins), .portb(portb_pins));

	eis_top u_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.porta_pins(porta_pins), .portf_pins(portf_pins), .portb_pins(portb_pins),
		.clock_controller_timebase(per[0]), .safe_oscillator_monitor(per[1]),
		.spi_irq(per[2]), .timer_a_irq(per[3]), .timer_b_irq(per[4]),
		.async_serial_port(per[5]), .aux_voltage_detector(per[6]), .twowire_irq(per[7]),
		.autoreload_pulse_timer(per[8]), .halt_mode(halt_mode),
		.active_halt_mode(active_halt_mode), .cpu_ack(cpu_ack), .cpu_ack_slot(cpu_ack_slot),
		.irq_req(irq_req), .irq_slot(irq_slot), .halt_wake(halt_wake),
		.ext_pending(ext_pending));

	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task give_verdict;
		begin
			$display("checks %0d failures %0d", n_checks, failures);
			if (failures == 0 && n_checks > 0) begin
				$display("bench passed");
			end else begin
				$display("bench failed");
			end
			$finish;
		end
	endtask

	task chk(input [8*6-1:0] nm, input [31:0] e, input [31:0] s);
		begin
			n_checks = n_checks + 1;
			if (s !== e) begin
				failures = failures + 1;
				$display("unexpected %0s expected %h seen %h", nm, e, s);
			end
		end
	endtask

	task wt(input integer k);
		begin
			repeat (k) @(posedge clk);
		end
	endtask

	// One bus access; request held until waitrequest is seen low
	task bus(input r, input [3:0] a, input [7:0] d);
		integer i;
		begin
			avs_address   <= a;
			avs_writedata <= {24'h0, d};
			avs_read      <= r;
			avs_write     <= ~r;
			i = 0;
			do begin
				@(posedge clk);
				i = i + 1;
			end while (avs_waitrequest !== 1'b0 && i < 20);
			rd = avs_readdata;
			avs_read  <= 1'b0;
			avs_write <= 1'b0;
			if (i >= 20) begin
				failures = failures + 1;
				give_verdict;
			end
			@(posedge clk);
		end
	endtask

	task ack(input [3:0] s);
		begin
			cpu_ack      <= 1'b1;
			cpu_ack_slot <= s;
			@(posedge clk);
			cpu_ack <= 1'b0;
		end
	endtask

	// Reset value, level gate, reserved bits, unmapped place
	task t_regs;
		begin
			bus(1'b1, `EIS_OFF_CTRL, 8'h00);
			chk("ctrl", 32'h0, rd);
			bus(1'b0, `EIS_OFF_CPU, {6'h0, `EIS_LEVEL0_CODE});
			bus(1'b0, `EIS_OFF_CTRL, 8'h18);
			bus(1'b1, `EIS_OFF_CTRL, 8'h00);
			chk("ctrl", 32'h0, rd);
			bus(1'b0, `EIS_OFF_CPU, {6'h0, `EIS_LEVEL3_CODE});
			bus(1'b0, `EIS_OFF_CTRL, 8'hff);
			bus(1'b1, `EIS_OFF_CTRL, 8'h00);
			chk("ctrl", 32'hfc, rd);
			bus(1'b0, 4'hf, 8'h55);
			bus(1'b1, 4'hf, 8'h00);
			chk("unmap", 32'h0, rd);
		end
	endtask

	// One group, one code, one polarity: edge out and back
	task t_sense(input integer gi, input [1:0] cd, input inv);
		reg [14:0] v;
		reg        ie;
		reg        s;
		reg        rh;
		reg        fh;
		integer    b;
		integer    p;
		begin
			b  = (gi == 0) ? 0 : (gi == 1) ? 4 : (gi == 2) ? 7 : 11;
			ie = inv & (gi == 0 || gi == 2);
			s  = (cd == 2'h0) ? ~ie : 1'b1;
			rh = (cd == 2'h3) | (cd == {ie, ~ie}) | (cd == 2'h0 & ie);
			fh = (cd == 2'h3) | (cd == {~ie, ie}) | (cd == 2'h0 & ~ie);
			p  = b + ((gi == 1) ? 2 : cd);
			v  = s ? 15'h7fff : 15'h7fff & ~(((gi == 1) ? 15'h7 : 15'hf) << b);
			pin_drv <= v;
			wt(8);
			bus(1'b0, `EIS_OFF_CTRL, gi[1] ? {cd, inv, 5'h0} : {3'h0, cd, inv, 2'h0});
			wt(6);
			ack(4'h2 + gi[3:0]);
			wt(4);
			chk("idle", 32'h0, ext_pending[gi]);
			v[p] = ~s;
			pin_drv <= v;
			wt(7);
			chk("first", s ? fh : rh, ext_pending[gi]);
			// Other group stays quiet only when this polarity bit is its own
			if (ie == inv) begin
				chk("slot", (s ? fh : rh) ? 4'h2 + gi : 4'hf, irq_slot);
				chk("wake", s ? fh : rh, halt_wake);
			end
			ack(4'h2 + gi[3:0]);
			wt(4);
			chk("level", cd == 2'h0, ext_pending[gi]);
			v[p] = s;
			pin_drv <= v;
			wt(7);
			chk("back", s ? rh : fh, ext_pending[gi]);
			ack(4'h2 + gi[3:0]);
			wt(4);
			chk("clear", 32'h0, ext_pending[gi]);
		end
	endtask

	// Same value keeps the latch, a changed value drops it
	task t_change;
		begin
			pin_drv <= 15'h7fff;
			bus(1'b0, `EIS_OFF_CTRL, 8'h10);
			wt(6);
			ack(4'h2);
			pin_drv <= 15'h7ffe;
			wt(7);
			chk("latch", 32'h1, ext_pending[0]);
			bus(1'b0, `EIS_OFF_CTRL, 8'h10);
			wt(3);
			chk("kept", 32'h1, ext_pending[0]);
			bus(1'b0, `EIS_OFF_CTRL, 8'h30);
			wt(3);
			chk("drop", 32'h0, ext_pending[0]);
			// New fall on port A, then software ack over the bus
			pin_drv <= 15'h7fff;
			wt(7);
			pin_drv <= 15'h7ffe;
			wt(7);
			bus(1'b1, `EIS_OFF_VEC, 8'h00);
			chk("vec", 32'h12, rd);
			bus(1'b0, `EIS_OFF_ACK, 8'h02);
			wt(3);
			bus(1'b1, `EIS_OFF_PEND, 8'h00);
			chk("pend", 32'h4, rd);
			pin_drv <= 15'h7fff;
			bus(1'b0, `EIS_OFF_CTRL, 8'h00);
			wt(6);
		end
	endtask

	// Peripheral slots alone and against the lowest one
	task t_periph;
		integer i;
		begin
			halt_mode <= 1'b1;
			for (i = 0; i < 9; i = i + 1) begin
				per <= 9'h1 << i;
				wt(4);
				chk("slot", (i < 2) ? 1 : i + 5, irq_slot);
				chk("wake", i == 2 || i == 8, halt_wake);
				per <= (9'h1 << i) | 9'h100;
				wt(4);
				chk("prio", (i < 2) ? 1 : i + 5, irq_slot);
			end
			halt_mode        <= 1'b0;
			active_halt_mode <= 1'b1;
			per              <= 9'h004;
			wt(4);
			chk("ahalt", 32'h0, halt_wake);
			per <= 9'h002;
			wt(4);
			chk("ahalt", 32'h1, halt_wake);
		end
	endtask

	initial begin
		rst              = 1'b1;
		avs_address      = 4'h0;
		avs_read         = 1'b0;
		avs_write        = 1'b0;
		avs_writedata    = 32'h0;
		pin_drv          = 15'h7fff;
		per              = 9'h0;
		halt_mode        = 1'b0;
		active_halt_mode = 1'b0;
		cpu_ack          = 1'b0;
		cpu_ack_slot     = 4'h0;
		failures         = 0;
		n_checks         = 0;
		wt(4);
		rst <= 1'b0;
		t_regs;
		halt_mode <= 1'b1;
		for (g = 0; g < 4; g = g + 1) begin
			for (c = 0; c < 4; c = c + 1) begin
				for (n = 0; n < 2; n = n + 1) begin
					t_sense(g, c[1:0], n[0]);
				end
			end
		end
		t_change;
		t_periph;
		give_verdict;
	end
endmodule

//--- src/eis_defs.vh
// Constants for the external interrupt sense and vector map block.
// Assumes inclusion by bare name from design files under src/.
`ifndef EIS_DEFS_VH
`define EIS_DEFS_VH

// ----------------------------------------
// Register map (word offsets, byte address = 4 x index)
// ----------------------------------------
`define EIS_ADDR_W        4
`define EIS_OFF_CTRL      4'h0
`define EIS_OFF_PEND      4'h1
`define EIS_OFF_SRC       4'h2
`define EIS_OFF_VEC       4'h3
`define EIS_OFF_CPU       4'h4
`define EIS_OFF_ACK       4'h5
`define EIS_OFF_HALT      4'h6

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define EIS_CTRL_RESET    8'h00
`define EIS_CTRL_WMASK    8'hfc
`define EIS_B_SENSE_HI    7
`define EIS_B_SENSE_LO    6
`define EIS_B_INV_BIT     5
`define EIS_AF_SENSE_HI   4
`define EIS_AF_SENSE_LO   3
`define EIS_A_INV_BIT     2

// ----------------------------------------
// Sense codes and priority levels
// ----------------------------------------
`define EIS_SENSE_FALL_LOW 2'h0
`define EIS_SENSE_RISE     2'h1
`define EIS_SENSE_FALL     2'h2
`define EIS_SENSE_BOTH     2'h3
`define EIS_LEVEL3_CODE    2'h3
`define EIS_LEVEL0_CODE    2'h2

// ----------------------------------------
// Vector slots
// ----------------------------------------
`define EIS_NSLOT         14
`define EIS_SLOT_CLK      4'h1
`define EIS_SLOT_EXT0     4'h2
`define EIS_SLOT_SPI      4'h7
`define EIS_SLOT_AVD      4'hb
`define EIS_SLOT_ART      4'hd
`define EIS_NO_SLOT       4'hf
// Slots allowed to end plain HALT: ext 2..5, serial periph 7, timer 13
`define EIS_HALT_WAKE     14'h20bc
// Slot allowed to end active-halt: clock controller
`define EIS_AHALT_WAKE    14'h0002

`endif

//--- src/eis_group_det.v
// Event detector for one external pin group.
// Assumes pins are already synchronised to clk.
`timescale 1ns/1ps
`include "eis_defs.vh"

module eis_group_det #(
	parameter W = 4
) (
	input  wire         clk,
	input  wire         rst,
	input  wire [W-1:0] pins,
	input  wire [1:0]   sense,
	input  wire         invert,
	output wire         edge_hit,
	output wire         level_hit
);
	reg  [W-1:0] prev_reg; // Previous sampled pins
	wire [W-1:0] rise;     // Per-pin rising edges
	wire [W-1:0] fall;     // Per-pin falling edges
	reg          e_hit;    // Edge event this cycle
	reg          l_hit;    // Active level present

	// ----------------------------------------
	// Previous sample
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			prev_reg <= {W{1'b1}};
		end else begin
			prev_reg <= pins;
		end
	end

	assign rise = pins & ~prev_reg;
	assign fall = ~pins & prev_reg;

	// ----------------------------------------
	// Sense decode, pins ORed per group
	// ----------------------------------------
	always @* begin
		e_hit = 1'b0;
		l_hit = 1'b0;
		case (sense)
			`EIS_SENSE_FALL_LOW: begin
				e_hit = invert ? |rise : |fall;
				l_hit = invert ? |pins : |(~pins);
			end
			`EIS_SENSE_RISE: begin
				e_hit = invert ? |fall : |rise;
			end
			`EIS_SENSE_FALL: begin
				e_hit = invert ? |rise : |fall;
			end
			default: begin
				e_hit = |rise | |fall;
			end
		endcase
	end

	assign edge_hit  = e_hit;
	assign level_hit = l_hit;
endmodule

//--- src/eis_sync.v
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps

module eis_sync #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         rst,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_reg; // First stage, read only by second
	reg [W-1:0] sync_reg; // Second stage, safe to use

	// ----------------------------------------
	// Sync chain
	// ----------------------------------------
	// Reset to high so idle pins do not fake falling edges
	always @(posedge clk) begin
		if (rst) begin
			meta_reg <= {W{1'b1}};
			sync_reg <= {W{1'b1}};
		end else begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end

	assign q = sync_reg;
endmodule

//--- src/eis_top.v
// External interrupt sensitivity control and fixed vector map.
// Assumes an Avalon-MM master on clk; pins arrive asynchronously;
// peripheral request lines and the CPU acknowledge are on clk.
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "eis_defs.vh"

module eis_top (
	input  wire        clk,
	input  wire        rst,
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	input  wire [3:0]  porta_pins,
	input  wire [2:0]  portf_pins,
	input  wire [7:0]  portb_pins,
	input  wire        clock_controller_timebase,
	input  wire        safe_oscillator_monitor,
	input  wire        spi_irq,
	input  wire        timer_a_irq,
	input  wire        timer_b_irq,
	input  wire        async_serial_port,
	input  wire        aux_voltage_detector,
	input  wire        twowire_irq,
	input  wire        autoreload_pulse_timer,
	input  wire        halt_mode,
	input  wire        active_halt_mode,
	input  wire        cpu_ack,
	input  wire [3:0]  cpu_ack_slot,
	output reg         irq_req,
	output reg  [3:0]  irq_slot,
	output reg         halt_wake,
	output reg  [3:0]  ext_pending
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	reg  [7:0]  ctrl_reg;         // Sensitivity control register
	reg  [1:0]  cpu_prio_reg;     // CPU priority copy, {high,low}
	reg  [3:0]  ext_latch_reg;    // Latched edge requests
	reg  [3:0]  ext_latch_next;   // Next latched requests
	wire [14:0] pin_raw;          // All pins bundled
	wire [14:0] pin_s;            // Synchronised pins
	wire [3:0]  edge_hit;         // Edge events per group
	wire [3:0]  level_hit;        // Level present per group
	wire [3:0]  ext_req;          // Requests per group
	wire [7:0]  ctrl_wr_val;      // Candidate control value
	wire        ctrl_wr;          // Control write strobe
	wire        cpu_wr;           // Priority copy write strobe
	wire        ack_wr;           // Software ack strobe
	wire        prio_locked;      // Level three in force
	wire        ctrl_changed;     // Write alters sense bits
	wire        ack_any;          // Ack from CPU or software
	wire [3:0]  ack_slot;         // Acknowledged slot
	reg  [13:0] slot_req;         // Requests by slot
	reg  [3:0]  best_slot;        // Highest priority slot
	reg         best_valid;       // Any slot requesting
	reg         wake;             // Wake condition
	reg  [31:0] rdata;            // Read mux
	integer     i;                // Pending clear loop
	integer     j;                // Priority loop, own index for one driver

	wire        bus_req = avs_read | avs_write;
	wire        bus_go  = bus_req & avs_waitrequest;
	// Writes land where the master sees waitrequest low, not a cycle early
	wire        bus_done = bus_req & ~avs_waitrequest;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	assign pin_raw = {portb_pins, portf_pins, porta_pins};

	eis_sync #(.W(15)) u_sync (
		.clk (clk),
		.rst (rst),
		.d   (pin_raw),
		.q   (pin_s)
	);

	// ----------------------------------------
	// Group detectors, one per external slot
	// ----------------------------------------
	// four groups
	eis_group_det #(.W(4)) u_det_a (
		.clk       (clk),
		.rst       (rst),
		.pins      (pin_s[3:0]),
		.sense     (ctrl_reg[`EIS_AF_SENSE_HI:`EIS_AF_SENSE_LO]),
		.invert    (ctrl_reg[`EIS_A_INV_BIT]),
		.edge_hit  (edge_hit[0]),
		.level_hit (level_hit[0])
	);

	eis_group_det #(.W(3)) u_det_f (
		.clk       (clk),
		.rst       (rst),
		.pins      (pin_s[6:4]),
		.sense     (ctrl_reg[`EIS_AF_SENSE_HI:`EIS_AF_SENSE_LO]),
		.invert    (1'b0),
		.edge_hit  (edge_hit[1]),
		.level_hit (level_hit[1])
	);

	eis_group_det #(.W(4)) u_det_bl (
		.clk       (clk),
		.rst       (rst),
		.pins      (pin_s[10:7]),
		.sense     (ctrl_reg[`EIS_B_SENSE_HI:`EIS_B_SENSE_LO]),
		.invert    (ctrl_reg[`EIS_B_INV_BIT]),
		.edge_hit  (edge_hit[2]),
		.level_hit (level_hit[2])
	);

	eis_group_det #(.W(4)) u_det_bh (
		.clk       (clk),
		.rst       (rst),
		.pins      (pin_s[14:11]),
		.sense     (ctrl_reg[`EIS_B_SENSE_HI:`EIS_B_SENSE_LO]),
		.invert    (1'b0),
		.edge_hit  (edge_hit[3]),
		.level_hit (level_hit[3])
	);

	// ----------------------------------------
	// Bus decode strobes
	// ----------------------------------------
	// Strobes fire on the completing edge of each access
	assign ctrl_wr = bus_done & avs_write & (avs_address == `EIS_OFF_CTRL) & avs_byteenable[0];
	assign cpu_wr  = bus_done & avs_write & (avs_address == `EIS_OFF_CPU) & avs_byteenable[0];
	assign ack_wr  = bus_done & avs_write & (avs_address == `EIS_OFF_ACK) & avs_byteenable[0];
	assign ctrl_wr_val = avs_writedata[7:0] & `EIS_CTRL_WMASK;
	assign prio_locked = (cpu_prio_reg == `EIS_LEVEL3_CODE);
	assign ctrl_changed = ctrl_wr & prio_locked & (ctrl_wr_val != ctrl_reg);

	// ----------------------------------------
	// Control and priority copy registers
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			ctrl_reg     <= `EIS_CTRL_RESET;
			// Priority copy starts disabled, as the CPU does
			cpu_prio_reg <= `EIS_LEVEL3_CODE;
		end else begin
			if (ctrl_wr && prio_locked) begin
				ctrl_reg <= ctrl_wr_val;
			end
			if (cpu_wr) begin
				cpu_prio_reg <= avs_writedata[1:0];
			end
		end
	end

	// ----------------------------------------
	// Pending external requests
	// ----------------------------------------
	assign ack_any  = cpu_ack | ack_wr;
	assign ack_slot = cpu_ack ? cpu_ack_slot : avs_writedata[3:0];

	always @* begin
		ext_latch_next = ext_latch_reg;
		for (i = 0; i < 4; i = i + 1) begin
			if (ack_any && ack_slot == `EIS_SLOT_EXT0 + i[3:0]) begin
				ext_latch_next[i] = 1'b0;
			end
		end
		if (ctrl_changed) begin
			ext_latch_next = 4'h0;
		end
		// edge latched; new event beats clear
		ext_latch_next = ext_latch_next | edge_hit;
	end

	always @(posedge clk) begin
		if (rst) begin
			ext_latch_reg <= 4'h0;
		end else begin
			ext_latch_reg <= ext_latch_next;
		end
	end

	assign ext_req = ext_latch_reg | level_hit;

	// ----------------------------------------
	// Slot map and fixed priority
	// ----------------------------------------
	always @* begin
		slot_req = 14'h0000;
		slot_req[1]  = clock_controller_timebase | safe_oscillator_monitor;
		slot_req[5:2] = ext_req;
		slot_req[7]  = spi_irq;
		slot_req[8]  = timer_a_irq;
		slot_req[9]  = timer_b_irq;
		slot_req[10] = async_serial_port;
		slot_req[11] = aux_voltage_detector;
		slot_req[12] = twowire_irq;
		slot_req[13] = autoreload_pulse_timer;
		best_slot  = `EIS_NO_SLOT;
		best_valid = 1'b0;
		// lowest index wins
		// Slot 0 never requests, so the scan stops at index 1
		for (j = `EIS_NSLOT - 1; j > 0; j = j - 1) begin
			if (slot_req[j]) begin
				best_slot  = j[3:0];
				best_valid = 1'b1;
			end
		end
		wake = (halt_mode & |(slot_req & `EIS_HALT_WAKE))
			| (active_halt_mode & |(slot_req & `EIS_AHALT_WAKE));
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @* begin
		// Unmapped offsets read as zero
		rdata = 32'h0000_0000;
		if (avs_address == `EIS_OFF_CTRL) begin
			rdata[7:0] = ctrl_reg;
		end else if (avs_address == `EIS_OFF_PEND) begin
			rdata[3:0] = ext_req;
		end else if (avs_address == `EIS_OFF_SRC) begin
			rdata[13:0] = slot_req;
		end else if (avs_address == `EIS_OFF_VEC) begin
			rdata[4:0] = {best_valid, best_slot};
		end else if (avs_address == `EIS_OFF_CPU) begin
			rdata[1:0] = cpu_prio_reg;
		end else if (avs_address == `EIS_OFF_HALT) begin
			rdata[0] = wake;
		end
	end

	// ----------------------------------------
	// Avalon slave and registered outputs
	// ----------------------------------------
	// One wait cycle per access keeps readdata registered
	always @(posedge clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
			irq_req         <= 1'b0;
			irq_slot        <= `EIS_NO_SLOT;
			halt_wake       <= 1'b0;
			ext_pending     <= 4'h0;
		end else begin
			if (bus_go) begin
				avs_waitrequest <= 1'b0;
				avs_readdata    <= avs_read ? rdata : 32'h0000_0000;
			end else begin
				avs_waitrequest <= 1'b1;
			end
			irq_req     <= best_valid;
			irq_slot    <= best_slot;
			halt_wake   <= wake;
			ext_pending <= ext_req;
		end
	end
endmodule
